/* hdl/usblp_defines.vh */
`ifndef USBLP_DEFINES_VH
`define USBLP_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define USBLP_ADDR_PERIODIC_BASE 32'h19000154
`define USBLP_ADDR_LIST_POINTER  32'h19000158
`define USBLP_ADDR_TT_CONTROL    32'h1900015c
`define USBLP_ADDR_BURST_LENGTH  32'h19000160
`define USBLP_ADDR_FILL_TUNING   32'h19000164

// ****************************************
// Field positions
// ****************************************
`define USBLP_PERIODIC_MSB 31
`define USBLP_PERIODIC_LSB 12
`define USBLP_EP_LIST_MSB 31
`define USBLP_EP_LIST_LSB 11
`define USBLP_ASYNC_MSB 31
`define USBLP_ASYNC_LSB 5
`define USBLP_HUB_ADDR_MSB 30
`define USBLP_HUB_ADDR_LSB 24
`define USBLP_RX_BURST_MSB 7
`define USBLP_RX_BURST_LSB 0
`define USBLP_TX_BURST_MSB 15
`define USBLP_TX_BURST_LSB 8
`define USBLP_THRESH_MSB 7
`define USBLP_THRESH_LSB 0
`define USBLP_HEALTH_MSB 12
`define USBLP_HEALTH_LSB 8
`define USBLP_SCHED_OH_MSB 21
`define USBLP_SCHED_OH_LSB 16

// ****************************************
// Reset values and limits
// ****************************************
`define USBLP_RST_PERIODIC 20'h00000
`define USBLP_RST_EP_LIST 21'h000000
`define USBLP_RST_ASYNC 27'h0000000
`define USBLP_RST_HUB_ADDR 7'h00
`define USBLP_RST_RX_BURST 8'h10
`define USBLP_RST_TX_BURST 8'h10
`define USBLP_RST_THRESH 8'h02
`define USBLP_MIN_THRESH 8'h02
`define USBLP_RST_SCHED_OH 6'h00
`define USBLP_HEALTH_MAX 5'h1f

`endif

/* hdl/usblp_prefill_sched.v */
`timescale 1ns/1ps
`default_nettype none

// Pre-fill admission and back-off decision for one transmit packet
module usblp_prefill_sched
(
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Packet and timing inputs, all times in one common tick unit
  input wire packet_found,
  input wire [15:0] frame_time_left,
  input wire [15:0] fetch_time,
  input wire [15:0] overhead_time,
  input wire [15:0] payload_time,
  input wire [5:0] sched_overhead,
  // Fill progress
  input wire [7:0] bursts_posted,
  input wire [7:0] burst_threshold,
  input wire stream_disable,
  // Decisions, one-cycle pulses
  output reg prefill_start,
  output reg packet_begin,
  output reg packet_retry,
  output reg latency_discard
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_FILL = 2'b10;

  reg [1:0] state_q;
  wire [17:0] send_time;
  wire [17:0] total_time;
  wire [17:0] left_ext;
  wire fill_reached;

  // Widened sums so a long fetch never wraps into an admission
  assign send_time = {2'b00, overhead_time} + {2'b00, payload_time};
  assign total_time = send_time + {2'b00, fetch_time} + {12'h000, sched_overhead};
  assign left_ext = {2'b00, frame_time_left};
  // Threshold does not apply when streaming is off
  assign fill_reached = stream_disable | (bursts_posted >= burst_threshold); // [RULE17]

  // Admission, fill watch and back-off
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      prefill_start <= 1'b0;
      packet_begin <= 1'b0;
      packet_retry <= 1'b0;
      latency_discard <= 1'b0;
    end
    else
    begin
      prefill_start <= 1'b0;
      packet_begin <= 1'b0;
      packet_retry <= 1'b0;
      latency_discard <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (packet_found && (left_ext >= total_time)) // [RULE13]
          begin
            prefill_start <= 1'b1;
            state_q <= ST_FILL;
          end
        end
        ST_FILL:
        begin
          if (left_ext < send_time) // [RULE14]
          begin
            // Not an error: retry later and free the latency buffer
            packet_retry <= 1'b1;
            latency_discard <= 1'b1; // [RULE15]
            state_q <= ST_IDLE;
          end
          else if (fill_reached)
          begin
            packet_begin <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* hdl/usblp_regs.v */
// Contract
// [RULE1] Periodic base bits 31:12, low bits reserved
// [RULE2] Fetch address from base plus frame index
// [RULE3] Driver sets periodic base before schedule start
// [RULE4] Endpoint pointer bits 10:0 read zero
// [RULE5] Up to four queue heads, aligned list
// [RULE6] Async pointer bits 4:0 read zero
// [RULE7] Async pointer names next queue head
// [RULE8] Hub address bits 30:24, host only
// [RULE9] Hub control written as full words only
// [RULE10] Burst lengths change live, full words
// [RULE11] Receive burst bits 7:0, reset 0x10
// [RULE12] Transmit burst bits 15:8, reset 0x10
// [RULE13] Pre-fill only if whole packet fits
// [RULE14] Abandon fill when send time short
// [RULE15] Back-off is no error, discard partial
// [RULE16] Health counter saturates, cleared on write; here a back-off in the same cycle as the write loads one
// [RULE17] Burst threshold minimum two, reset two
// [RULE18] Shared address shows active role layout
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "usblp_defines.vh"

module usblp_regs
(
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Register port
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  // Controller role and frame position
  input wire host_mode,
  input wire [13:0] frame_index_counter,
  input wire [1:0] qh_select,
  // List pointers toward the DMA master
  output reg [31:0] periodic_fetch_addr,
  output reg [31:0] endpoint_qh_addr,
  output reg [31:0] async_qh_addr,
  output reg [6:0] translator_hub_address,
  // Burst tuning toward the DMA master
  output reg [7:0] receive_burst_words,
  output reg [7:0] transmit_burst_words,
  output reg [7:0] fifo_burst_threshold,
  // Transmit pre-fill scheduling
  input wire packet_found,
  input wire [15:0] frame_time_left,
  input wire [15:0] fetch_time,
  input wire [15:0] overhead_time,
  input wire [15:0] payload_time,
  input wire [7:0] bursts_posted,
  input wire stream_disable,
  output wire prefill_start,
  output wire packet_begin,
  output wire packet_retry,
  output wire latency_discard,
  output reg [4:0] scheduler_health_count
);

  // ****************************************
  // Address decode
  // ****************************************

  // Exact word match; used for both the write and the read path
  function hit;
    input [31:0] addr;
    input [31:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  wire wr_periodic;
  wire wr_list;
  wire wr_tt;
  wire wr_burst;
  wire wr_fill;

  // Writes land in the view of the role now active
  assign wr_periodic = reg_write & host_mode & hit(reg_addr, `USBLP_ADDR_PERIODIC_BASE);
  assign wr_list = reg_write & hit(reg_addr, `USBLP_ADDR_LIST_POINTER); // [RULE18]
  assign wr_tt = reg_write & host_mode & hit(reg_addr, `USBLP_ADDR_TT_CONTROL); // [RULE8]
  assign wr_burst = reg_write & hit(reg_addr, `USBLP_ADDR_BURST_LENGTH);
  assign wr_fill = reg_write & host_mode & hit(reg_addr, `USBLP_ADDR_FILL_TUNING);

  // ****************************************
  // Stored fields
  // ****************************************

  reg [19:0] periodic_base_field_q;
  reg [20:0] endpoint_list_field_q;
  reg [26:0] async_link_field_q;
  reg [5:0] sched_overhead_q;
  wire [7:0] threshold_wr;
  wire [4:0] health_d;

  // A threshold below the minimum is raised to it on the write
  assign threshold_wr = (reg_wdata[`USBLP_THRESH_MSB:`USBLP_THRESH_LSB] < `USBLP_MIN_THRESH) ?
    `USBLP_MIN_THRESH : reg_wdata[`USBLP_THRESH_MSB:`USBLP_THRESH_LSB]; // [RULE17]

  // Periodic list base; only the upper pointer bits are kept
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      periodic_base_field_q <= `USBLP_RST_PERIODIC;
    end
    else if (wr_periodic)
    begin
      periodic_base_field_q <= reg_wdata[`USBLP_PERIODIC_MSB:`USBLP_PERIODIC_LSB]; // [RULE1]
    end
  end

  // Shared address: separate storage per role, so a role swap loses neither pointer
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      endpoint_list_field_q <= `USBLP_RST_EP_LIST;
      async_link_field_q <= `USBLP_RST_ASYNC;
    end
    else if (wr_list)
    begin
      if (host_mode)
      begin
        async_link_field_q <= reg_wdata[`USBLP_ASYNC_MSB:`USBLP_ASYNC_LSB]; // [RULE6]
      end
      else
      begin
        endpoint_list_field_q <= reg_wdata[`USBLP_EP_LIST_MSB:`USBLP_EP_LIST_LSB]; // [RULE4]
      end
    end
  end

  // Hub address for directly attached full- and low-speed devices
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      translator_hub_address <= `USBLP_RST_HUB_ADDR;
    end
    else if (wr_tt)
    begin
      // No byte lanes on this port, so every write is a full word
      translator_hub_address <= reg_wdata[`USBLP_HUB_ADDR_MSB:`USBLP_HUB_ADDR_LSB]; // [RULE9]
    end
  end

  // Burst lengths in both roles
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      receive_burst_words <= `USBLP_RST_RX_BURST;
      transmit_burst_words <= `USBLP_RST_TX_BURST;
    end
    else if (wr_burst)
    begin
      // Takes effect on the next burst even mid-transfer
      receive_burst_words <= reg_wdata[`USBLP_RX_BURST_MSB:`USBLP_RX_BURST_LSB]; // [RULE11]
      transmit_burst_words <= reg_wdata[`USBLP_TX_BURST_MSB:`USBLP_TX_BURST_LSB]; // [RULE12]
    end
  end

  // Fill tuning, host view only
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      fifo_burst_threshold <= `USBLP_RST_THRESH;
      sched_overhead_q <= `USBLP_RST_SCHED_OH;
    end
    else if (wr_fill)
    begin
      fifo_burst_threshold <= threshold_wr;
      sched_overhead_q <= reg_wdata[`USBLP_SCHED_OH_MSB:`USBLP_SCHED_OH_LSB];
    end
  end

  // ****************************************
  // DMA address formation
  // ****************************************

  // Registered so the fetch engine sees a stable word every cycle
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      periodic_fetch_addr <= 32'h00000000;
      endpoint_qh_addr <= 32'h00000000;
      async_qh_addr <= 32'h00000000;
    end
    else
    begin
      // One 4-byte entry per frame, 1024 entries in the 4 kB page
      periodic_fetch_addr <= {periodic_base_field_q, frame_index_counter[12:3], 2'b00}; // [RULE2]
      // Four 64-byte queue heads from the list top
      endpoint_qh_addr <= {endpoint_list_field_q, 3'b000, qh_select, 6'b000000}; // [RULE5]
      // Next queue head the host will execute
      async_qh_addr <= {async_link_field_q, 5'b00000}; // [RULE7]
    end
  end

  // ****************************************
  // Scheduler health counter
  // ****************************************

  // A back-off in the clearing cycle still counts, so the set wins
  assign health_d = wr_fill ? (packet_retry ? 5'h01 : 5'h00) :
    ((packet_retry && (scheduler_health_count != `USBLP_HEALTH_MAX)) ?
    (scheduler_health_count + 5'h01) : scheduler_health_count);

  // Saturating count of back-off events
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      scheduler_health_count <= 5'h00;
    end
    else
    begin
      scheduler_health_count <= health_d; // [RULE16]
    end
  end

  // ****************************************
  // Pre-fill scheduler
  // ****************************************

  // Only host transmit traffic is scheduled here
  usblp_prefill_sched u_sched
  (
    .clock(clock),
    .resetn(resetn),
    .packet_found(packet_found & host_mode),
    .frame_time_left(frame_time_left),
    .fetch_time(fetch_time),
    .overhead_time(overhead_time),
    .payload_time(payload_time),
    .sched_overhead(sched_overhead_q),
    .bursts_posted(bursts_posted),
    .burst_threshold(fifo_burst_threshold),
    .stream_disable(stream_disable),
    .prefill_start(prefill_start),
    .packet_begin(packet_begin),
    .packet_retry(packet_retry),
    .latency_discard(latency_discard)
  );

  // ****************************************
  // Read path
  // ****************************************

  reg [31:0] read_word;

  // Reserved bits and host-only registers in device mode read zero
  always @*
  begin
    read_word = 32'h00000000;
    if (hit(reg_addr, `USBLP_ADDR_PERIODIC_BASE))
    begin
      if (host_mode)
      begin
        read_word = {periodic_base_field_q, 12'h000}; // [RULE1]
      end
    end
    else if (hit(reg_addr, `USBLP_ADDR_LIST_POINTER))
    begin
      if (host_mode)
      begin
        read_word = {async_link_field_q, 5'b00000}; // [RULE6]
      end
      else
      begin
        read_word = {endpoint_list_field_q, 11'h000}; // [RULE4]
      end
    end
    else if (hit(reg_addr, `USBLP_ADDR_TT_CONTROL))
    begin
      if (host_mode)
      begin
        read_word = {1'b0, translator_hub_address, 24'h000000}; // [RULE8]
      end
    end
    else if (hit(reg_addr, `USBLP_ADDR_BURST_LENGTH))
    begin
      read_word = {16'h0000, transmit_burst_words, receive_burst_words}; // [RULE10]
    end
    else if (hit(reg_addr, `USBLP_ADDR_FILL_TUNING))
    begin
      if (host_mode)
      begin
        read_word = {10'h000, sched_overhead_q, 3'b000, scheduler_health_count, fifo_burst_threshold};
      end
    end
  end

  // Read data stand for the one cycle after the strobe
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= 32'h00000000;
    end
    else if (reg_read)
    begin
      reg_rdata <= read_word;
    end
    else
    begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

/* verification/usblp_frame_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Microframe timing seen by the controller
// ****************************************
module usblp_frame_timer #(parameter int TICKS = 600)
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Frame position toward the controller
  output logic [15:0] frame_time_left,
  output logic [13:0] frame_index_counter
);
  // Count down each microframe; the index steps one list entry per wrap
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      frame_time_left <= 16'(TICKS - 1);
      frame_index_counter <= 14'h0;
    end
    else if (frame_time_left == 16'h0)
    begin
      frame_time_left <= 16'(TICKS - 1);
      frame_index_counter <= frame_index_counter + 14'h8;
    end
    else
      frame_time_left <= frame_time_left - 16'h1;
  end
endmodule
`default_nettype wire

/* verification/usblp_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checks of the list and burst bank
// ****************************************
module usblp_regs_chk
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port and role
  input wire logic [31:0] reg_addr,
  input wire logic reg_write,
  input wire logic host_mode,
  input wire logic [13:0] frame_index_counter,
  input wire logic [1:0] qh_select,
  // Pointers and tuning
  input wire logic [31:0] periodic_fetch_addr,
  input wire logic [31:0] endpoint_qh_addr,
  input wire logic [31:0] async_qh_addr,
  input wire logic [7:0] receive_burst_words,
  input wire logic [7:0] transmit_burst_words,
  input wire logic [7:0] fifo_burst_threshold,
  // Scheduler
  input wire logic packet_found,
  input wire logic [15:0] frame_time_left,
  input wire logic [15:0] fetch_time,
  input wire logic [15:0] overhead_time,
  input wire logic [15:0] payload_time,
  input wire logic prefill_start,
  input wire logic packet_retry,
  input wire logic latency_discard,
  input wire logic [4:0] scheduler_health_count
);
  // A host write to the tuning word clears the health count
  wire logic clr;
  assign clr = reg_write && host_mode && reg_addr == 32'h19000164;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_burst_reset: assert property ($rose(resetn) |-> receive_burst_words == 8'h10 &&
    transmit_burst_words == 8'h10 && fifo_burst_threshold == 8'h02) else $error("burst reset values wrong");
  a_thresh_floor: assert property (fifo_burst_threshold >= 8'h02) else $error("threshold below two");
  a_backoff_pair: assert property (packet_retry == latency_discard) else $error("discard not with retry");
  a_health_step: assert property (packet_retry && !clr && scheduler_health_count != 5'h1f |=>
    scheduler_health_count == $past(scheduler_health_count) + 5'h01) else $error("health not counted");
  a_health_sat: assert property (scheduler_health_count == 5'h1f && !clr |=>
    scheduler_health_count == 5'h1f) else $error("health not saturated");
  // Sums are widened so three large times cannot wrap into a false pass
  a_admit_fit: assert property (prefill_start |-> $past(packet_found && host_mode &&
    {2'b00, frame_time_left} >= {2'b00, fetch_time} + overhead_time + payload_time))
    else $error("fill admitted late");
  a_retry_short: assert property (packet_retry |->
    $past({2'b00, frame_time_left} < {2'b00, overhead_time} + payload_time)) else $error("retry without shortage");
  a_list_align: assert property (async_qh_addr[4:0] == 5'h0 && endpoint_qh_addr[5:0] == 6'h0 &&
    periodic_fetch_addr[1:0] == 2'h0) else $error("pointer low bits set");
  a_frame_step: assert property ($past(resetn) |->
    periodic_fetch_addr[11:2] == $past(frame_index_counter[12:3])) else $error("frame entry wrong");
  a_qh_select: assert property ($past(resetn) |-> endpoint_qh_addr[10:6] == {3'h0, $past(qh_select)})
    else $error("queue head select wrong");
endmodule
bind usblp_regs usblp_regs_chk usblp_regs_chk_i (.clock, .resetn, .reg_addr, .reg_write, .host_mode,
  .frame_index_counter, .qh_select, .periodic_fetch_addr, .endpoint_qh_addr, .async_qh_addr,
  .receive_burst_words, .transmit_burst_words, .fifo_burst_threshold, .packet_found, .frame_time_left,
  .fetch_time, .overhead_time, .payload_time, .prefill_start, .packet_retry, .latency_discard,
  .scheduler_health_count);
`default_nettype wire

/* verification/usblp_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module usblp_regs_tb_top;
  localparam logic [31:0] BASE = 32'h19000154;
  logic clock = 0, resetn = 0, reg_write = 0, reg_read = 0, host_mode = 1, packet_found = 0, stream_disable = 0;
  logic [31:0] reg_addr = 0, reg_wdata = 0, reg_rdata, periodic_fetch_addr, endpoint_qh_addr, async_qh_addr;
  logic [31:0] lf = 32'd56;
  logic [31:0] m [6];
  logic [1:0] qh_select = 2'h2;
  logic [15:0] frame_time_left, fetch_time = 0, overhead_time = 0, payload_time = 0;
  logic [13:0] frame_index_counter;
  logic [7:0] bursts_posted = 0, receive_burst_words, transmit_burst_words, fifo_burst_threshold;
  logic [6:0] translator_hub_address;
  logic [4:0] scheduler_health_count;
  logic prefill_start, packet_begin, packet_retry, latency_discard;
  int err_total = 0, checks = 0, cyc = 0, hlt = 0, i, j, n_ps = 0, n_pb = 0, n_pr = 0, n_ld = 0;

  usblp_regs usblp_regs_i (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .host_mode, .frame_index_counter, .qh_select, .periodic_fetch_addr, .endpoint_qh_addr, .async_qh_addr,
    .translator_hub_address, .receive_burst_words, .transmit_burst_words, .fifo_burst_threshold,
    .packet_found, .frame_time_left, .fetch_time, .overhead_time, .payload_time, .bursts_posted,
    .stream_disable, .prefill_start, .packet_begin, .packet_retry, .latency_discard, .scheduler_health_count);
  usblp_frame_timer usblp_frame_timer_i (.clock, .resetn, .frame_time_left, .frame_index_counter);

  initial forever #5 clock = ~clock;
  // Pulse tally; an unknown pulse counts so it cannot hide
  always @(posedge clock)
  begin
    cyc++;
    // Outputs are unknown before the first reset edge, so count only after release
    if (resetn)
    begin
      n_ps += (prefill_start !== 1'b0);
      n_pb += (packet_begin !== 1'b0);
      n_pr += (packet_retry !== 1'b0);
      n_ld += (latency_discard !== 1'b0);
    end
    if (cyc == 20000)
    begin
      err_total++;
      end_sim;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Read model: host-only words read zero in device mode
  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    case (a)
      BASE: return host_mode ? m[0] : 32'h0;
      BASE + 4: return host_mode ? m[1] : m[5];
      BASE + 8: return host_mode ? m[2] : 32'h0;
      BASE + 12: return m[3];
      BASE + 16: return host_mode ? (m[4] | (hlt << 8)) : 32'h0;
      default: return 32'h0;
    endcase
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Full-word write; the model keeps only the writable fields
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    if (a == BASE + 4 && !host_mode) m[5] = d & 32'hfffff800;
    if (a == BASE + 12) m[3] = d & 32'h0000ffff;
    if (host_mode)
    begin
      if (a == BASE) m[0] = d & 32'hfffff000;
      if (a == BASE + 4) m[1] = d & 32'hffffffe0;
      if (a == BASE + 8) m[2] = d & 32'h7f000000;
      if (a == BASE + 16) m[4] = (d & 32'h003f0000) | ((d[7:0] < 8'h2) ? 32'h2 : {24'h0, d[7:0]});
      if (a == BASE + 16) hlt = 0;
    end
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    cmp(reg_rdata, exp_rd(a));
  endtask
  task automatic role(input logic h);
    @(posedge clock);
    host_mode <= h;
    @(negedge clock);
  endtask
  // One packet offer; a back-off offer makes the send time exactly fill the frame
  task automatic pk(input logic [15:0] f, input bit bk);
    for (j = 0; j < 700 && frame_time_left < 16'd50; j++) @(posedge clock);
    @(posedge clock);
    fetch_time <= f;
    overhead_time <= bk ? frame_time_left - 16'h1 : 16'ha;
    payload_time <= bk ? 16'h0 : 16'ha;
    packet_found <= 1'b1;
    @(posedge clock);
    packet_found <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic end_sim;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    m = '{32'h0, 32'h0, 32'h0, 32'h1010, 32'h2, 32'h0};
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++) rd(BASE + 4 * i);
    // Random words in both roles, then the host view again; index 5 is unmapped
    for (int r = 0; r < 3; r++)
    begin
      role(r != 1);
      for (i = 0; i < 6; i++)
      begin
        lf = lfsr(lf);
        qh_select <= lf[1:0];
        wr(BASE + 4 * i, lf);
      end
      if (r == 0) wr(BASE + 16, 32'h00000001);
      for (i = 0; i < 6; i++) rd(BASE + 4 * i);
    end
    role(1'b1);
    for (i = 0; i < 6; i++) rd(BASE + 4 * i);
    cmp(periodic_fetch_addr & 32'hfffff000, m[0]);
    cmp(async_qh_addr, m[1]);
    cmp(endpoint_qh_addr, m[5] | {qh_select, 6'h0});
    cmp({translator_hub_address, 24'h0}, m[2]);
    cmp({transmit_burst_words, receive_burst_words}, m[3]);
    cmp(fifo_burst_threshold, m[4] & 32'hff);
    // Scheduler: base and tuning set before any packet
    wr(BASE, 32'h12345000);
    wr(BASE + 16, 32'h00000002);
    bursts_posted <= 8'h2;
    pk(16'ha, 0);
    bursts_posted <= 8'h0;
    stream_disable <= 1'b1;
    pk(16'ha, 0);
    stream_disable <= 1'b0;
    pk(16'h1000, 0);
    for (i = 0; i < 33; i++)
    begin
      pk(16'h0, 1);
      hlt = (hlt < 31) ? hlt + 1 : 31;
    end
    rd(BASE + 16);
    // The largest scheduler overhead turns away a packet that would just fit without it
    wr(BASE + 16, 32'h003f0002);
    pk(16'h0, 1);
    rd(BASE + 16);
    role(1'b0);
    pk(16'ha, 0);
    role(1'b1);
    cmp(n_ps, 35);
    cmp(n_pb, 2);
    cmp(n_pr, 33);
    cmp(n_ld, 33);
    wr(BASE + 16, 32'h00000002);
    rd(BASE + 16);
    end_sim;
  end
endmodule
`default_nettype wire
